// ===== pkg/ssa_pkg.sv
// Package of constants and carrier types for the shared SDRAM arbiter
package ssa_pkg;
    localparam int HADDR_W = 22;
    localparam int DATA_W = 32;
    localparam int ROW_W = 11;
    localparam int COL_W = 8;
    localparam int BANK_W = 1;
    localparam int COL_LSB = 2;
    localparam int BANK_LSB = 10;
    localparam int ROW_LSB = 11;
    localparam int BURST_LEN = 8;
    localparam int MEM_CLK_DIV = 1;
    localparam int CLK_MHZ = 100;
    localparam int INIT_WAIT_US = 200;
    localparam int INIT_WAIT_CYC = INIT_WAIT_US * CLK_MHZ;
    localparam int REFRESH_NS = 15600;
    localparam int REFRESH_CYC = REFRESH_NS * CLK_MHZ / 1000;
    localparam int TRP_CYC = 2;
    localparam int TRCD_CYC = 2;
    localparam int TRFC_CYC = 7;
    localparam int CAS_LAT = 2;
    // Read wait covers CAS, model launch and the two dq sync stages
    localparam int RD_WAIT_CYC = CAS_LAT + 3;
    localparam int INIT_REFRESHES = 8;
    localparam logic [11:0] MODE_WORD = 12'h023;
    localparam logic [11:0] A10_ALL = 12'h400;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_RD = 4'h5;
    localparam logic [3:0] CMD_WR = 4'h4;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_MRS = 4'h0;

    typedef enum logic [3:0] {
        SSA_INIT_WAIT, SSA_INIT_PRE, SSA_INIT_REF, SSA_INIT_MRS, SSA_IDLE,
        SSA_ACT, SSA_CMD, SSA_XFER, SSA_PRE, SSA_REF, SSA_WAIT
    } ssa_state_t;

    typedef struct packed {
        logic rd_gnt;
        logic wr_gnt;
        logic [DATA_W-1:0] rdata;
    } ssa_host_rsp_t;

    typedef struct packed {
        logic [3:0] cmd;
        logic [BANK_W-1:0] ba;
        logic [11:0] addr;
        logic [DATA_W-1:0] dq;
        logic dq_oe_n;
        logic clk;
    } ssa_mem_out_t;

    typedef struct packed {
        ssa_state_t st;
        ssa_state_t after;
        logic [15:0] cnt;
        logic [3:0] beat;
        logic [3:0] nref;
        logic [15:0] refc;
        logic ref_due;
        logic hw_pend;
        logic hr_pend;
        logic host_cur;
        logic gfx_cur;
        logic gfx_last;
        logic [HADDR_W-1:0] haddr;
        logic [DATA_W-1:0] hwdata;
        logic [3:0] hbe;
        logic [HADDR_W-1:0] gaddr;
        logic [2:0] sync_cs;
        logic [2:0] sync_cs2;
        logic [2:0] sync_cs3;
        ssa_host_rsp_t rsp;
        logic gfx_valid;
        logic gfx_ack;
        logic [DATA_W-1:0] gfx_data;
        ssa_mem_out_t mem;
    } ssa_state_reg_t;
endpackage

// ===== design/ssa_arbiter.sv
// Shared SDRAM controller serving host bus and graphics engine
`timescale 1ns/1ps
module ssa_arbiter (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic clk_en_in,
    input wire logic cs_reg_n_in,
    input wire logic cs_mem_n_in,
    input wire logic host_we_in,
    input wire logic [ssa_pkg::HADDR_W-1:0] host_addr_in,
    input wire logic [ssa_pkg::DATA_W-1:0] host_wdata_in,
    input wire logic [3:0] host_be_in,
    input wire logic gfx_req_in,
    input wire logic [ssa_pkg::HADDR_W-1:0] gfx_addr_in,
    input wire logic [ssa_pkg::DATA_W-1:0] mem_dq_in,
    output logic reg_sel_out,
    output ssa_pkg::ssa_host_rsp_t host_rsp_out,
    output logic gfx_ack_out,
    output logic gfx_valid_out,
    output logic [ssa_pkg::DATA_W-1:0] gfx_data_out,
    output ssa_pkg::ssa_mem_out_t mem_out,
    output logic [3:0] mem_dqm_n_out
);
    ssa_pkg::ssa_state_reg_t s_reg;
    ssa_pkg::ssa_state_reg_t s_next;
    logic [ssa_pkg::DATA_W-1:0] dq_s1_reg;
    logic [ssa_pkg::DATA_W-1:0] dq_s2_reg;
    logic [3:0] dqm_reg;
    logic [3:0] dqm_next;
    logic cs_mem_req;
    logic [ssa_pkg::HADDR_W-1:0] cur_addr;

    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            dq_s1_reg <= '0;
            dq_s2_reg <= '0;
        end
        else if (clk_en_in)
        begin
            dq_s1_reg <= mem_dq_in;
            dq_s2_reg <= dq_s1_reg;
        end
    end

    // select decode
    // Edge taken past the second flop; first flop may be metastable
    assign cs_mem_req = s_reg.sync_cs2[1] & ~s_reg.sync_cs3[1];
    assign cur_addr = s_reg.host_cur ? s_reg.haddr : s_reg.gaddr;

    always_comb
    begin
        s_next = s_reg;
        dqm_next = 4'h0;
        s_next.sync_cs = {host_we_in, ~cs_mem_n_in, ~cs_reg_n_in};
        s_next.sync_cs2 = s_reg.sync_cs;
        s_next.sync_cs3 = s_reg.sync_cs2;
        s_next.rsp.rd_gnt = 1'b0;
        s_next.rsp.wr_gnt = 1'b0;
        s_next.gfx_valid = 1'b0;
        s_next.gfx_ack = 1'b0;
        s_next.mem.cmd = ssa_pkg::CMD_NOP;
        s_next.mem.dq_oe_n = 1'b1;
        s_next.mem.clk = ~s_reg.mem.clk;
        if (s_reg.cnt != ssa_pkg::CNT_ZERO)
            s_next.cnt = s_reg.cnt - 16'h0001;
        if (s_reg.refc == 16'(ssa_pkg::REFRESH_CYC - 1))
        begin
            s_next.refc = ssa_pkg::CNT_ZERO;
            s_next.ref_due = 1'b1;
        end
        else
            s_next.refc = s_reg.refc + 16'h0001;
        if (cs_mem_req && s_reg.sync_cs2[2] && !s_reg.hw_pend
            && !s_reg.hr_pend)
        begin
            s_next.hw_pend = 1'b1;
            s_next.haddr = host_addr_in;
            s_next.hwdata = host_wdata_in;
            s_next.hbe = host_be_in;
            s_next.rsp.wr_gnt = 1'b1;
        end
        else if (cs_mem_req && !s_reg.sync_cs2[2] && !s_reg.hw_pend
                 && !s_reg.hr_pend)
        begin
            s_next.hr_pend = 1'b1;
            s_next.haddr = host_addr_in;
        end
        case (s_reg.st)
            ssa_pkg::SSA_INIT_WAIT:
                if (s_reg.cnt == ssa_pkg::CNT_ZERO)
                begin
                    s_next.mem.cmd = ssa_pkg::CMD_PRE;
                    s_next.mem.addr = ssa_pkg::A10_ALL;
                    s_next.cnt = 16'(ssa_pkg::TRP_CYC);
                    s_next.st = ssa_pkg::SSA_INIT_PRE;
                end
            ssa_pkg::SSA_INIT_PRE:
                if (s_reg.cnt == ssa_pkg::CNT_ZERO)
                    s_next.st = ssa_pkg::SSA_INIT_REF;
            ssa_pkg::SSA_INIT_REF:
                if (s_reg.cnt == ssa_pkg::CNT_ZERO)
                begin
                    if (s_reg.nref == 4'(ssa_pkg::INIT_REFRESHES))
                    begin
                        s_next.mem.cmd = ssa_pkg::CMD_MRS;
                        s_next.mem.addr = ssa_pkg::MODE_WORD;
                        s_next.cnt = 16'(ssa_pkg::TRP_CYC);
                        s_next.st = ssa_pkg::SSA_INIT_MRS;
                    end
                    else
                    begin
                        s_next.mem.cmd = ssa_pkg::CMD_REF;
                        s_next.nref = s_reg.nref + 4'h1;
                        s_next.cnt = 16'(ssa_pkg::TRFC_CYC);
                    end
                end
            ssa_pkg::SSA_INIT_MRS:
                if (s_reg.cnt == ssa_pkg::CNT_ZERO)
                    s_next.st = ssa_pkg::SSA_IDLE;
            ssa_pkg::SSA_IDLE:
            begin
                if (s_reg.ref_due)
                begin
                    s_next.ref_due = 1'b0;
                    s_next.mem.cmd = ssa_pkg::CMD_REF;
                    s_next.cnt = 16'(ssa_pkg::TRFC_CYC);
                    s_next.st = ssa_pkg::SSA_WAIT;
                end
                else if (gfx_req_in && !(s_reg.gfx_last
                         && (s_reg.hw_pend || s_reg.hr_pend)))
                begin
                    s_next.gfx_ack = 1'b1;
                    s_next.gaddr = gfx_addr_in;
                    s_next.gfx_cur = 1'b1;
                    s_next.host_cur = 1'b0;
                    s_next.gfx_last = 1'b1;
                    s_next.st = ssa_pkg::SSA_ACT;
                end
                else if (s_reg.hw_pend || s_reg.hr_pend)
                begin
                    s_next.host_cur = 1'b1;
                    s_next.gfx_cur = 1'b0;
                    s_next.gfx_last = 1'b0;
                    s_next.st = ssa_pkg::SSA_ACT;
                end
            end
            ssa_pkg::SSA_ACT:
            begin
                s_next.mem.cmd = ssa_pkg::CMD_ACT;
                s_next.mem.ba = cur_addr[ssa_pkg::BANK_LSB];
                s_next.mem.addr = {1'b0, cur_addr[ssa_pkg::HADDR_W-1:
                                   ssa_pkg::ROW_LSB]};
                s_next.cnt = 16'(ssa_pkg::TRCD_CYC);
                s_next.st = ssa_pkg::SSA_CMD;
            end
            ssa_pkg::SSA_CMD:
                if (s_reg.cnt == ssa_pkg::CNT_ZERO)
                begin
                    s_next.mem.addr = {4'h0, cur_addr[ssa_pkg::BANK_LSB-1:
                                       ssa_pkg::COL_LSB]};
                    if (s_reg.host_cur && s_reg.hw_pend)
                    begin
                        s_next.mem.cmd = ssa_pkg::CMD_WR;
                        s_next.mem.dq = s_reg.hwdata;
                        s_next.mem.dq_oe_n = 1'b0;
                        dqm_next = ~s_reg.hbe;
                        s_next.beat = 4'h1;
                    end
                    else
                    begin
                        s_next.mem.cmd = ssa_pkg::CMD_RD;
                        s_next.beat = s_reg.gfx_cur ?
                            4'(ssa_pkg::BURST_LEN) : 4'h1;
                    end
                    s_next.cnt = 16'(ssa_pkg::RD_WAIT_CYC);
                    s_next.st = ssa_pkg::SSA_XFER;
                end
            ssa_pkg::SSA_XFER:
                if (s_reg.cnt == ssa_pkg::CNT_ZERO)
                begin
                    if (s_reg.host_cur && s_reg.hw_pend)
                    begin
                        s_next.hw_pend = 1'b0;
                        s_next.st = ssa_pkg::SSA_PRE;
                    end
                    else if (s_reg.host_cur)
                    begin
                        s_next.rsp.rdata = dq_s2_reg;
                        s_next.rsp.rd_gnt = 1'b1;
                        s_next.hr_pend = 1'b0;
                        s_next.st = ssa_pkg::SSA_PRE;
                    end
                    else
                    begin
                        s_next.gfx_data = dq_s2_reg;
                        s_next.gfx_valid = 1'b1;
                        s_next.beat = s_reg.beat - 4'h1;
                        if (s_reg.beat == 4'h1)
                            s_next.st = ssa_pkg::SSA_PRE;
                    end
                end
            ssa_pkg::SSA_PRE:
            begin
                s_next.mem.cmd = ssa_pkg::CMD_PRE;
                s_next.mem.addr = ssa_pkg::A10_ALL;
                s_next.cnt = 16'(ssa_pkg::TRP_CYC);
                s_next.st = ssa_pkg::SSA_WAIT;
            end
            ssa_pkg::SSA_WAIT:
                if (s_reg.cnt == ssa_pkg::CNT_ZERO)
                    s_next.st = ssa_pkg::SSA_IDLE;
            default:
                s_next.st = ssa_pkg::SSA_IDLE;
        endcase
    end

    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            s_reg <= '0;
            s_reg.st <= ssa_pkg::SSA_INIT_WAIT;
            s_reg.cnt <= 16'(ssa_pkg::INIT_WAIT_CYC);
            s_reg.mem.cmd <= ssa_pkg::CMD_NOP;
            s_reg.mem.dq_oe_n <= 1'b1;
            dqm_reg <= 4'h0;
        end
        else if (clk_en_in)
        begin
            s_reg <= s_next;
            dqm_reg <= dqm_next;
        end
    end

    assign reg_sel_out = s_reg.sync_cs2[0];
    assign host_rsp_out = s_reg.rsp;
    assign gfx_ack_out = s_reg.gfx_ack;
    assign gfx_valid_out = s_reg.gfx_valid;
    assign gfx_data_out = s_reg.gfx_data;
    assign mem_out = s_reg.mem;
    assign mem_dqm_n_out = dqm_reg;

    chk_read_stall: assert property (@(posedge clock_in) disable iff (srst_in)
        host_rsp_out.rd_gnt |-> $past(s_reg.hr_pend))
        else $error("read answered with no pending read");
    chk_write_ack: assert property (@(posedge clock_in) disable iff (srst_in)
        host_rsp_out.wr_gnt |-> s_reg.hw_pend)
        else $error("write ack without buffered write");
    // no second graphics grant over waiting host
    chk_host_bound: assert property (@(posedge clock_in) disable iff (srst_in)
        (gfx_ack_out && $past(s_reg.gfx_last) && $past(s_reg.st)
         == ssa_pkg::SSA_IDLE) |-> !$past(s_reg.hw_pend || s_reg.hr_pend))
        else $error("host starved by two graphics bursts");
    chk_ref_idle: assert property (@(posedge clock_in) disable iff (srst_in)
        (clk_en_in && s_reg.st == ssa_pkg::SSA_XFER) |=>
        mem_out.cmd != ssa_pkg::CMD_REF)
        else $error("refresh inside a burst");
    chk_gfx_burst: assert property (@(posedge clock_in) disable iff (srst_in)
        (mem_out.cmd == ssa_pkg::CMD_RD && s_reg.gfx_cur) |->
        s_reg.beat == 4'(ssa_pkg::BURST_LEN))
        else $error("graphics read not a burst of eight");
    chk_init_quiet: assert property (@(posedge clock_in) disable iff (srst_in)
        s_reg.st == ssa_pkg::SSA_INIT_WAIT |->
        mem_out.cmd == ssa_pkg::CMD_NOP)
        else $error("command issued during power-up wait");
endmodule

// ===== verif/ssa_sdram_model.sv
// Behavioural model of the two x16 SDRAM parts on the memory bus
`timescale 1ns/1ps
module ssa_sdram_model (
    input wire logic clock_in,
    input wire ssa_pkg::ssa_mem_out_t mem_in,
    output logic [31:0] mem_dq_out
);
    logic [31:0] mem_arr [int];
    logic [10:0] row_reg [2];
    logic [31:0] rd_reg;
    logic [7:0] pipe_reg;
    int key;
    initial
    begin
        mem_dq_out = 32'h0;
        rd_reg = 32'h0;
        pipe_reg = 8'h00;
    end
    // Data held four cycles; outside that the bus wanders
    always @(posedge clock_in)
    begin
        key = {row_reg[mem_in.ba], mem_in.ba, mem_in.addr[7:0]};
        pipe_reg <= {pipe_reg[6:0], mem_in.cmd === ssa_pkg::CMD_RD};
        if (mem_in.cmd === ssa_pkg::CMD_ACT)
            row_reg[mem_in.ba] <= mem_in.addr[10:0];
        if (mem_in.cmd === ssa_pkg::CMD_WR && mem_in.dq_oe_n === 1'b0)
            mem_arr[key] = mem_in.dq;
        if (mem_in.cmd === ssa_pkg::CMD_RD)
            rd_reg <= mem_arr.exists(key) ? mem_arr[key] : 32'h0;
        mem_dq_out <= (|pipe_reg[4:1]) ? rd_reg : ~mem_dq_out;
    end
endmodule

// ===== verif/tb_ssa_arbiter.sv
// Self-checking bench for the shared SDRAM arbiter
`timescale 1ns/1ps
module tb_ssa_arbiter;
    logic clock_in = 1'b0;
    logic srst_in = 1'b1;
    logic cs_reg_n = 1'b1;
    logic cs_mem_n = 1'b1;
    logic we = 1'b0;
    logic gfx_req = 1'b0;
    logic [21:0] haddr = 22'h000000;
    logic [21:0] gaddr = 22'h000100;
    logic [31:0] wdata = 32'h0;
    logic [31:0] dq;
    logic reg_sel;
    logic gfx_ack;
    logic gfx_valid;
    ssa_pkg::ssa_host_rsp_t rsp;
    ssa_pkg::ssa_mem_out_t mem;
    int failures = 0;
    int tests_run = 0;
    int acks = 0;
    int ack_at_gnt;
    int refs = 0;
    int acts = 0;
    logic open = 1'b0;
    logic [10:0] act_row;
    logic act_ba;
    logic [7:0] col;
    logic [21:0] adr [5] = '{22'h000000, 22'h3FFFFC, 22'h0007FC,
        22'h000800, 22'h2AAAA8};

    always #5 clock_in = ~clock_in;

    ssa_arbiter dut (.clock_in(clock_in), .srst_in(srst_in),
        .clk_en_in(1'b1), .cs_reg_n_in(cs_reg_n), .cs_mem_n_in(cs_mem_n),
        .host_we_in(we), .host_addr_in(haddr), .host_wdata_in(wdata),
        .host_be_in(4'hF), .gfx_req_in(gfx_req), .gfx_addr_in(gaddr),
        .mem_dq_in(dq), .reg_sel_out(reg_sel), .host_rsp_out(rsp),
        .gfx_ack_out(gfx_ack), .gfx_valid_out(gfx_valid),
        .gfx_data_out(), .mem_out(mem), .mem_dqm_n_out());
    ssa_sdram_model sdram (.clock_in(clock_in), .mem_in(mem),
        .mem_dq_out(dq));

    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic timeout(input string what);
        failures++;
        $display("[FAIL] %s expected done seen timeout", what);
        print_verdict();
    endtask

    // Refresh must never land inside an open row; sampled mid-cycle
    always @(negedge clock_in)
    begin
        acks += (gfx_ack === 1'b1);
        if (mem.cmd === ssa_pkg::CMD_ACT)
        begin
            open = 1'b1;
            acts++;
            act_row = mem.addr[10:0];
            act_ba = mem.ba;
        end
        if (mem.cmd === ssa_pkg::CMD_PRE)
            open = 1'b0;
        if (mem.cmd === ssa_pkg::CMD_RD || mem.cmd === ssa_pkg::CMD_WR)
            col = mem.addr[7:0];
        if (mem.cmd === ssa_pkg::CMD_REF)
            refs++;
        if (mem.cmd === ssa_pkg::CMD_REF)
            check("ref_in_open_row", 32'h0, {31'h0, open});
    end

    // host port is one 32-bit word per access
    task automatic host_op(input logic w, input logic [21:0] a,
        input logic [31:0] d, output logic [31:0] q, output int n);
        @(posedge clock_in);
        we <= w;
        haddr <= a;
        wdata <= d;
        cs_mem_n <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clock_in);
            #1;
            n++;
            if (n > 800)
                timeout("host_gnt");
        end
        while (!(w ? rsp.wr_gnt === 1'b1 : rsp.rd_gnt === 1'b1));
        q = rsp.rdata;
        ack_at_gnt = acks;
        @(posedge clock_in);
        cs_mem_n <= 1'b1;
        repeat (3) @(posedge clock_in);
    endtask

    task automatic t_init();
        int n;
        int pre;
        int nref;
        int tog;
        logic ck;
        pre = 0;
        nref = 0;
        tog = 0;
        ck = mem.clk;
        for (n = 0; mem.cmd !== ssa_pkg::CMD_MRS; n++)
        begin
            @(posedge clock_in);
            #1;
            tog += (mem.clk !== ck);
            ck = mem.clk;
            pre += (mem.cmd === ssa_pkg::CMD_PRE && mem.addr[10] === 1'b1);
            nref += (mem.cmd === ssa_pkg::CMD_REF);
            if (n > 25000)
                timeout("init");
        end
        check("init_wait", 32'h1, {31'h0, n >= 20000});
        check("init_precharge", 32'h1, pre);
        check("init_refreshes", 32'h8, nref);
        check("mode_word", {20'h0, ssa_pkg::MODE_WORD}, {20'h0, mem.addr});
        check("mem_clock_runs", 32'h1, {31'h0, tog > 0});
        $display("test init done");
    endtask

    // Linear map: boundary words written, then read back from SDRAM
    task automatic t_linear();
        logic [31:0] q;
        int n;
        foreach (adr[i])
        begin
            host_op(1'b1, adr[i], {10'h2A5, adr[i]}, q, n);
            check("wr_gnt_latency", 32'h1, {31'h0, n <= 4});
            repeat (40) @(posedge clock_in);
            check("act_row", {21'h0, adr[i][21:11]}, {21'h0, act_row});
            check("act_bank", {31'h0, adr[i][10]}, {31'h0, act_ba});
            check("col", {24'h0, adr[i][9:2]}, {24'h0, col});
        end
        foreach (adr[i])
        begin
            host_op(1'b0, adr[i], 32'h0, q, n);
            check("read_data", {10'h2A5, adr[i]}, q);
        end
        $display("test linear done");
    endtask

    task automatic t_regsel();
        int a0;
        a0 = acts;
        @(posedge clock_in);
        cs_reg_n <= 1'b0;
        repeat (5) @(posedge clock_in);
        #1;
        check("reg_sel_on", 32'h1, {31'h0, reg_sel});
        cs_reg_n <= 1'b1;
        repeat (5) @(posedge clock_in);
        #1;
        check("reg_sel_off", 32'h0, {31'h0, reg_sel});
        check("no_sdram_cmd", a0, acts);
        $display("test regsel done");
    endtask

    task automatic t_gfx();
        int nv;
        nv = 0;
        @(posedge clock_in);
        gfx_req <= 1'b1;
        for (int n = 0; n < 300; n++)
        begin
            @(posedge clock_in);
            #1;
            nv += (gfx_valid === 1'b1);
            if (gfx_ack === 1'b1)
                gfx_req <= 1'b0;
        end
        check("burst_beats", 32'h8, nv);
        $display("test gfx done");
    endtask

    // Graphics held asking; host read lands behind exactly one burst
    task automatic t_contend();
        logic [31:0] q;
        int n;
        int a0;
        a0 = acks;
        gfx_req <= 1'b1;
        host_op(1'b0, adr[1], 32'h0, q, n);
        gfx_req <= 1'b0;
        check("gfx_first", 32'h1, {31'h0, ack_at_gnt - a0 >= 1});
        check("host_behind_one", 32'h1, ack_at_gnt - a0);
        check("contend_data", {10'h2A5, adr[1]}, q);
        repeat (200) @(posedge clock_in);
        $display("test contend done");
    endtask

    task automatic t_refresh();
        int r0;
        r0 = refs;
        repeat (1700) @(posedge clock_in);
        check("periodic_refresh", 32'h1, {31'h0, refs > r0});
        $display("test refresh done");
    endtask

    initial
    begin
        repeat (4) @(posedge clock_in);
        srst_in <= 1'b0;
        t_init();
        t_linear();
        t_regsel();
        t_gfx();
        t_contend();
        t_contend();
        t_refresh();
        print_verdict();
    end
endmodule
